// >>> logic/sdm_pkg.sv
// Shared constants and types for the switch detect and mux block
package sdm_pkg;

  // ************************************************************
  // Sizes
  // ************************************************************
  localparam int WORD_W = 24;          // Serial word length
  localparam int N_IN = 22;            // Switch inputs in total
  localparam int N_PROG = 8;           // Programmable inputs, bits 0..7
  localparam int CH_W = 5;             // Analog channel code width
  localparam int N_PINS = 27;          // Synchronised pins: 22 sense + 5 link/ctl

  // ************************************************************
  // Command word fields
  // ************************************************************
  localparam int OP_HI = 23;           // Opcode field top bit
  localparam int OP_LO = 16;           // Opcode field bottom bit
  localparam int INT_T_HI = 5;         // Interrupt timer field
  localparam int INT_T_LO = 3;
  localparam int SCAN_T_HI = 2;        // Scan timer field
  localparam int SCAN_T_LO = 0;
  localparam int ANA_CH_LO = 0;        // Analog channel code position
  localparam int ANA_OPT_LO = 5;       // Analog current option position

  // ************************************************************
  // Opcodes
  // ************************************************************
  localparam logic [7:0] OP_STATUS = 8'h00;
  localparam logic [7:0] OP_SETTINGS = 8'h01;
  localparam logic [7:0] OP_WET_TIMER = 8'h02;
  localparam logic [7:0] OP_TRISTATE = 8'h03;
  localparam logic [7:0] OP_METALLIC = 8'h04;
  localparam logic [7:0] OP_ANALOG = 8'h05;
  localparam logic [7:0] OP_SLEEP = 8'h0C;

  // ************************************************************
  // Analog current options
  // ************************************************************
  localparam logic [1:0] ANA_HIZ = 2'h0;
  localparam logic [1:0] ANA_LOW = 2'h1;
  localparam logic [1:0] ANA_HIGH = 2'h2;

  // ************************************************************
  // Values after reset
  // ************************************************************
  localparam logic [N_PROG-1:0] RST_BATT_TYPE = 8'hFF;
  localparam logic [N_IN-1:0] RST_TRISTATE = 22'h3FFFFF;
  localparam logic [N_IN-1:0] RST_METALLIC = 22'h3FFFFF;
  localparam logic [N_IN-1:0] RST_WET_EN = 22'h3FFFFF;
  localparam logic [CH_W-1:0] RST_ANA_CH = 5'h1F;
  localparam logic [2:0] RST_TIMER = 3'h0;
  localparam logic [N_PINS-1:0] RST_PINS = 27'h7000000;

  // Operating modes
  typedef enum logic {SDM_NORMAL, SDM_SLEEP} sdm_mode_e;

endpackage : sdm_pkg

// >>> logic/sdm_link_if.sv
// Frame carrier between the serial shifter and the block core
`timescale 1ns/10ps
interface sdm_link_if;
  import sdm_pkg::*;

  logic frame_start;                   // Pulse, chip select fell
  logic frame_end;                     // Pulse, chip select rose
  logic frame_active;                  // Level, chip select low
  logic [WORD_W-1:0] rx_word;          // Last word held at frame end
  logic [WORD_W-1:0] tx_word;          // Status word loaded at frame start

  modport core (input frame_start, input frame_end, input frame_active,
    input rx_word, output tx_word);
  modport link (output frame_start, output frame_end, output frame_active,
    output rx_word, input tx_word);
endinterface : sdm_link_if

// >>> logic/sdm_sync.sv
// Two-flop synchroniser for a bus of independent pin levels
`timescale 1ns/10ps
module sdm_sync
  import sdm_pkg::*;
#(
  parameter int W = N_PINS,
  parameter logic [W-1:0] RST_VAL = '0
)(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [W-1:0] pins,
  output logic [W-1:0] synced
);

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    logic [W-1:0] s1;                  // First stage, read by s2 only
    logic [W-1:0] s2;                  // Second stage, safe to use
  } sdm_sync_s;

  sdm_sync_s q;
  sdm_sync_s d;

  initial
  begin
    if (W < 1) $error("sdm_sync: width must be at least 1");
  end

  // Next state
  always_comb
  begin
    d = q;
    d.s1 = pins;
    d.s2 = q.s1;
  end

  // Registers
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      q <= '{s1: RST_VAL, s2: RST_VAL};
    end
    else
    begin
      q <= d;
    end
  end

  assign synced = q.s2;

endmodule : sdm_sync

// >>> logic/sdm_shift.sv
// 24-bit serial shifter, slave of the host link, daisy-chain capable
`timescale 1ns/10ps
module sdm_shift
  import sdm_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic sclk_s,
  input wire logic cs_n_s,
  input wire logic si_s,
  output logic so,
  output logic so_oe_n,
  sdm_link_if.link link
);

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    logic sclk_prev;                   // Last sampled link clock
    logic cs_prev;                     // Last sampled chip select
    logic [WORD_W-1:0] shreg;          // Shift register
    logic [WORD_W-1:0] rx;             // Word held at frame end
    logic so;                          // Serial out bit
    logic so_oe_n;                     // Low while driving serial out
    logic start;                       // Frame start pulse
    logic stop;                        // Frame end pulse
  } sdm_shift_s;

  sdm_shift_s q;
  sdm_shift_s d;

  // Edge finding and shifting
  always_comb
  begin
    d = q;
    d.sclk_prev = sclk_s;
    d.cs_prev = cs_n_s;
    d.start = q.cs_prev & ~cs_n_s;
    d.stop = ~q.cs_prev & cs_n_s;
    d.so_oe_n = cs_n_s;
    if (q.cs_prev && !cs_n_s)
    begin
      // Frame opens: load status, first bit out
      d.shreg = link.tx_word;
      d.so = link.tx_word[WORD_W-1];
    end
    else if (!cs_n_s && !q.sclk_prev && sclk_s)
    begin
      // Rising link clock: take serial in
      d.shreg = {q.shreg[WORD_W-2:0], si_s};
    end
    else if (!cs_n_s && q.sclk_prev && !sclk_s)
    begin
      // Falling link clock: present next bit, passes chain on
      d.so = q.shreg[WORD_W-1];
    end
    if (!q.cs_prev && cs_n_s)
    begin
      // Frame closes: last 24 bits are the command
      d.rx = q.shreg;
    end
  end

  // Registers
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      q <= '{sclk_prev: 1'b0, cs_prev: 1'b1, shreg: '0, rx: '0, so: 1'b0,
        so_oe_n: 1'b1, start: 1'b0, stop: 1'b0};
    end
    else
    begin
      q <= d;
    end
  end

  assign so = q.so;
  assign so_oe_n = q.so_oe_n;
  assign link.frame_start = q.start;
  assign link.frame_end = q.stop;
  assign link.frame_active = ~q.cs_prev;
  assign link.rx_word = q.rx;

endmodule : sdm_shift

// >>> logic/sdm_top.sv
// Switch detect front end core: command decode, drives, mux, sleep
//
// Contract
// - Analog command selects one of 22 at frame end
// - Selected analog input reads 0 in status
// - Analog input current: off, low or high
// - Reset: normal mode, all inputs tri-stated
// - Programmable inputs source or sink by type
// - Battery type, not tri-stated, sinks to ground
// - Ground type sources; battery type sinks again
// - Ground input senses while tri-stated; low reads 1
// - High only above comparator threshold
// - Ground input current follows tri-state bit
// - Sleep command takes effect at frame end
// - Sleep releases the wake line high
// - Wake drives line low; falling line wakes
// - Input change during sleep frame stays normal
// - No select wake without logic supply
// - Internal supply reset restores all defaults
// - Sleep word: interrupt timer 5:3, scan 2:0
// - Select falling wakes device with supply present
`timescale 1ns/10ps
module sdm_top
  import sdm_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic sclk_pin,
  input wire logic cs_n_pin,
  input wire logic si_pin,
  output logic so_pin,
  output logic so_oe_n,
  input wire logic [N_IN-1:0] sense_above_thr,
  input wire logic logic_supply_ok,
  input wire logic wake_n_in,
  output logic wake_n_out,
  output logic wake_n_oe_n,
  output logic [N_IN-1:0] src_en,
  output logic [N_IN-1:0] sink_en,
  output logic [N_IN-1:0] hi_current,
  output logic [CH_W-1:0] analog_select_out,
  output logic analog_valid,
  output logic sleep_mode,
  output logic [2:0] int_timer_sel,
  output logic [2:0] scan_timer_sel
);

  // ************************************************************
  // Elaboration checks
  // ************************************************************
  initial
  begin
    if (N_IN > (1 << CH_W)) $error("sdm_top: channel code too narrow");
    if (N_PROG > N_IN) $error("sdm_top: more programmable than total");
  end

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  logic [N_PINS-1:0] pins_s;           // Synchronised pin levels
  logic sclk_s;                        // Link clock, synchronised
  logic cs_n_s;                        // Chip select, synchronised
  logic si_s;                          // Serial in, synchronised
  logic wake_s;                        // Wake line, synchronised
  logic supply_s;                      // Logic supply good, synchronised
  logic [N_IN-1:0] sense_s;            // Comparator outputs, synchronised

  // Packed: supply, wake, cs, sclk, si, sense
  sdm_sync #(.W(N_PINS), .RST_VAL(RST_PINS)) u_sync (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .pins({supply_s_pin_order(logic_supply_ok, wake_n_in), cs_n_pin,
      sclk_pin, si_pin, sense_above_thr}),
    .synced(pins_s)
  );

  // Unpack in the packed order
  assign sense_s = pins_s[N_IN-1:0];
  assign si_s = pins_s[N_IN];
  assign sclk_s = pins_s[N_IN+1];
  assign cs_n_s = pins_s[N_IN+2];
  assign wake_s = pins_s[N_IN+3];
  assign supply_s = pins_s[N_IN+4];

  // ************************************************************
  // Serial shifter
  // ************************************************************
  // Frame events from the shifter
  sdm_link_if link ();

  sdm_shift u_shift (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .sclk_s(sclk_s),
    .cs_n_s(cs_n_s),
    .si_s(si_s),
    .so(so_pin),
    .so_oe_n(so_oe_n),
    .link(link.link)
  );

  // ************************************************************
  // Helper functions
  // ************************************************************

  // Packs supply and wake in pin-bus order
  function automatic logic [1:0] supply_s_pin_order(input logic sup, input logic wk);
    supply_s_pin_order = {sup, wk};
  endfunction : supply_s_pin_order

  // Switch state as reported: 1 means closed or open-load
  function automatic logic sw_bit(input int idx, input logic above,
    input logic batt);
    logic res;
    res = 1'b0;
    if (idx < N_PROG && batt)
    begin
      // Battery switch closes by pulling pin high
      res = above;
    end
    else
    begin
      // Ground switch: low pin reads 1, even tri-stated
      res = ~above;
    end
    sw_bit = res;
  endfunction : sw_bit

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    sdm_mode_e mode;                   // Normal or sleep
    logic [N_PROG-1:0] batt_type;      // 1 battery type, 0 ground type
    logic [N_IN-1:0] tristate;         // 1 current source off
    logic [N_IN-1:0] metallic;         // 1 high current, 0 low
    logic [N_IN-1:0] wet_en;           // Wetting timer enables
    logic [CH_W-1:0] ana_ch;           // Analog channel code
    logic [1:0] ana_opt;               // Analog current option
    logic [2:0] int_t;                 // Interrupt timer field
    logic [2:0] scan_t;                // Scan timer field
    logic [N_IN-1:0] snap;             // Switch states at frame start
    logic changed;                     // Input changed in this frame
    logic wake_prev;                   // Last wake line level
    logic [WORD_W-1:0] status;         // Next status word
    logic [N_IN-1:0] src;              // Source drive out
    logic [N_IN-1:0] sink;             // Sink drive out
    logic [N_IN-1:0] hi;               // High current out
    logic [CH_W-1:0] ana_out;          // Analog select out
    logic ana_valid;                   // Analog channel in range, normal mode only
    logic wake_oe_n;                   // Low while pulling wake low
  } sdm_top_s;

  // All state in one record; d is next
  sdm_top_s q;
  sdm_top_s d;

  // ************************************************************
  // Next-state logic
  // ************************************************************

  logic [N_IN-1:0] raw;                // Switch states right now
  logic [7:0] opcode;                  // Opcode of received word
  logic [N_IN-1:0] payload;            // Data bits of received word
  logic ana_ok;                        // Next analog code in range

  // Raw switch states
  always_comb
  begin
    raw = '0;
    for (int i = 0; i < N_IN; i++)
    begin
      raw[i] = sw_bit(i, sense_s[i], (i < N_PROG) ? q.batt_type[i % N_PROG] : 1'b0);
    end
  end

  // Data 21:16 overlap the opcode field
  assign opcode = link.rx_word[OP_HI:OP_LO];
  assign payload = link.rx_word[N_IN-1:0];

  // Mode, command decode and drive outputs
  always_comb
  begin
    d = q;
    d.wake_prev = wake_s;
    // Track input change across a frame
    if (link.frame_start)
    begin
      d.snap = raw;
      d.changed = 1'b0;
    end
    else if (link.frame_active && raw != q.snap)
    begin
      d.changed = 1'b1;
    end
    if (q.mode == SDM_SLEEP)
    begin
      // Frame end is ignored while asleep
      // Wake from select fall with supply, or falling wake line
      if (link.frame_start && supply_s)
      begin
        d.mode = SDM_NORMAL;
      end
      else if (q.wake_prev && !wake_s)
      begin
        d.mode = SDM_NORMAL;
      end
    end
    else if (link.frame_end)
    begin
      // Act on the word held at frame end
      case (opcode)
        OP_SETTINGS:
        begin
          d.batt_type = payload[N_PROG-1:0];
        end
        OP_WET_TIMER:
        begin
          d.wet_en = payload;
        end
        OP_TRISTATE:
        begin
          d.tristate = payload;
        end
        OP_METALLIC:
        begin
          d.metallic = payload;
        end
        OP_ANALOG:
        begin
          d.ana_ch = link.rx_word[ANA_CH_LO +: CH_W];
          d.ana_opt = link.rx_word[ANA_OPT_LO +: 2];
        end
        OP_SLEEP:
        begin
          // Change seen during the frame keeps normal mode
          if (!q.changed && raw == q.snap)
          begin
            d.mode = SDM_SLEEP;
            d.int_t = link.rx_word[INT_T_HI:INT_T_LO];
            d.scan_t = link.rx_word[SCAN_T_HI:SCAN_T_LO];
          end
        end
        default:
        begin
          // Status read and unknown opcodes change nothing
          d.mode = q.mode;
        end
      endcase
    end
    // Analog channel in range of the inputs
    // Bad codes leave inputs as set
    ana_ok = (d.ana_ch < CH_W'(N_IN));
    d.ana_out = d.ana_ch;
    d.ana_valid = ana_ok && (d.mode == SDM_NORMAL);
    // Current drives per input
    d.src = '0;
    d.sink = '0;
    d.hi = '0;
    for (int i = 0; i < N_IN; i++)
    begin
      if (d.mode == SDM_SLEEP)
      begin
        // Sleep: every source off
        d.src[i] = 1'b0;
      end
      else if (ana_ok && d.ana_ch == CH_W'(i))
      begin
        // Analog channel: pull-up per option
        d.src[i] = (d.ana_opt == ANA_LOW) || (d.ana_opt == ANA_HIGH);
        d.hi[i] = (d.ana_opt == ANA_HIGH);
      end
      else if (!d.tristate[i])
      begin
        if (i < N_PROG && d.batt_type[i % N_PROG])
        begin
          d.sink[i] = 1'b1;
        end
        else
        begin
          d.src[i] = 1'b1;
        end
        d.hi[i] = d.metallic[i];
      end
    end
    // Status word; selected analog bit reads 0
    // Mask keeps the analog bit at 0
    d.status = '0;
    for (int i = 0; i < N_IN; i++)
    begin
      d.status[i] = raw[i] & ~(ana_ok && d.ana_ch == CH_W'(i));
    end
    // Wake line: driven low in normal, released in sleep
    d.wake_oe_n = (d.mode == SDM_SLEEP);
  end

  // ************************************************************
  // Registers
  // ************************************************************
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      // Async reset, constants only
      // Supply reset: normal mode, all defaults, inputs tri-stated
      q <= '{mode: SDM_NORMAL, batt_type: RST_BATT_TYPE, tristate: RST_TRISTATE,
        metallic: RST_METALLIC, wet_en: RST_WET_EN, ana_ch: RST_ANA_CH,
        ana_opt: ANA_HIZ, int_t: RST_TIMER, scan_t: RST_TIMER, snap: '0,
        changed: 1'b0, wake_prev: 1'b1, status: '0, src: '0, sink: '0,
        hi: '0, ana_out: RST_ANA_CH, ana_valid: 1'b0,
        wake_oe_n: 1'b0};
    end
    else
    begin
      q <= d;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  // Outputs other than the wake value are plain register copies
  assign link.tx_word = q.status;
  // Open drain: value low, enable acts
  assign wake_n_out = 1'b0;
  assign wake_n_oe_n = q.wake_oe_n;
  assign src_en = q.src;
  assign sink_en = q.sink;
  assign hi_current = q.hi;
  assign analog_select_out = q.ana_out;
  assign analog_valid = q.ana_valid;
  assign sleep_mode = (q.mode == SDM_SLEEP);
  assign int_timer_sel = q.int_t;
  assign scan_timer_sel = q.scan_t;

endmodule : sdm_top

// >>> verif/sdm_top_sva.sv
// Concurrent checks on the switch detect block ports
`timescale 1ns/10ps
module sdm_top_sva
  import sdm_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic cs_n_pin,
  input wire logic logic_supply_ok,
  input wire logic wake_n_in,
  input wire logic wake_n_out,
  input wire logic wake_n_oe_n,
  input wire logic so_oe_n,
  input wire logic [N_IN-1:0] src_en,
  input wire logic [N_IN-1:0] sink_en,
  input wire logic [CH_W-1:0] analog_select_out,
  input wire logic analog_valid,
  input wire logic sleep_mode
);
  // ****************************************
  // Clocking and sequences
  // ****************************************
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);
  // Asleep, no logic supply, wake line idle high
  sequence s_dead_quiet;
    (sleep_mode && !logic_supply_ok && wake_n_in) [*5];
  endsequence
  // Select held low with the supply present
  sequence s_frame_open;
    (!cs_n_pin && logic_supply_ok) [*6];
  endsequence
  // ****************************************
  // Assertions
  // ****************************************
  a_channel_range: assert property (analog_valid |-> analog_select_out < N_IN)
    else $error("analog channel flagged valid beyond last input");
  a_reset_state: assert property ($rose(reset_n) |-> !sleep_mode && src_en == '0
    && sink_en == '0 && analog_select_out == RST_ANA_CH)
    else $error("state after reset not at defaults");
  a_sleep_entry: assert property ($rose(sleep_mode) |-> cs_n_pin && $past(cs_n_pin, 3))
    else $error("sleep entered while select low");
  a_sleep_release: assert property ($rose(sleep_mode) |-> ##[0:2] wake_n_oe_n)
    else $error("wake line not released in sleep");
  a_sleep_drives: assert property (sleep_mode [*3] |-> src_en == '0 && sink_en == '0)
    else $error("current drive left on in sleep");
  a_wake_select: assert property (sleep_mode && logic_supply_ok && $fell(cs_n_pin)
    |-> ##[1:8] !sleep_mode)
    else $error("select fall did not wake");
  a_wake_line: assert property (sleep_mode && $fell(wake_n_in) |-> ##[1:6] !sleep_mode)
    else $error("wake line fall did not wake");
  a_wake_pull: assert property ($fell(sleep_mode) |-> ##[0:2] (!wake_n_oe_n && !wake_n_out))
    else $error("wake line not pulled low after wake");
  a_no_dead_wake: assert property (s_dead_quiet |=> sleep_mode)
    else $error("woke without logic supply");
  a_drive_exclusive: assert property ((src_en & sink_en) == '0)
    else $error("input sources and sinks at once");
  a_so_enable: assert property (s_frame_open |-> !so_oe_n)
    else $error("serial out not driven in frame");
  a_so_release: assert property (cs_n_pin [*5] |-> so_oe_n)
    else $error("serial out driven outside frame");
endmodule : sdm_top_sva
bind sdm_top sdm_top_sva u_sva (.core_clk, .reset_n, .cs_n_pin, .logic_supply_ok, .wake_n_in,
  .wake_n_out, .wake_n_oe_n, .so_oe_n, .src_en, .sink_en, .analog_select_out, .analog_valid,
  .sleep_mode);

// >>> verif/sdm_host_model.sv
// Host link master model: frames, MSB first, clock idle low
`timescale 1ns/10ps
module sdm_host_model
(
  input wire logic core_clk,
  output logic sclk,
  output logic cs_n,
  output logic si,
  input wire logic so
);
  // ****************************************
  // Frame transfer
  // ****************************************
  // Shifts n bits out and collects n bits from serial out
  task automatic xfer(input logic [47:0] w, input int n, output logic [47:0] r);
    r = '0;
    @(negedge core_clk);
    cs_n = 1'b0;
    for (int i = n - 1; i >= 0; i--)
    begin
      si = w[i];
      #80;
      r[i] = so;                        // Settled before rising edge
      sclk = 1'b1;
      #80;
      sclk = 1'b0;                      // Clock rests low between bits
    end
    si = ~si;                           // No stale data after frame
    #80;
    cs_n = 1'b1;                        // Device acts on last 24 bits
    #240;                               // Gap well over five cycles
  endtask : xfer
  // Idle levels at time zero
  initial
  begin
    sclk = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
  end
endmodule : sdm_host_model

// >>> verif/testbench.sv
// Self-checking bench for the switch detect block
`timescale 1ns/10ps
module testbench;
  import sdm_pkg::*;
  logic core_clk, reset_n, sclk_pin, cs_n_pin, si_pin, so_pin, so_oe_n, so_line;
  logic logic_supply_ok, wake_n_in, wake_n_out, wake_n_oe_n, other_wake_n;
  logic [N_IN-1:0] sense_above_thr, src_en, sink_en, hi_current;
  logic [CH_W-1:0] analog_select_out;
  logic analog_valid, sleep_mode;
  logic [2:0] int_timer_sel, scan_timer_sel;
  logic [31:0] lfsr = 32'h6583;
  logic [31:0] r;
  logic [47:0] rx;
  logic [7:0] batt;
  int n_errors, comparisons, p, g, ch;
  // Released serial out toggles; wake line is open drain with pull-up
  assign so_line = so_oe_n ? core_clk : so_pin;
  assign wake_n_in = (wake_n_oe_n ? 1'b1 : wake_n_out) & other_wake_n;
  sdm_top DUT (.core_clk, .reset_n, .sclk_pin, .cs_n_pin, .si_pin, .so_pin, .so_oe_n,
    .sense_above_thr, .logic_supply_ok, .wake_n_in, .wake_n_out, .wake_n_oe_n, .src_en,
    .sink_en, .hi_current, .analog_select_out, .analog_valid, .sleep_mode, .int_timer_sel,
    .scan_timer_sel);
  sdm_host_model u_host (.core_clk, .sclk(sclk_pin), .cs_n(cs_n_pin), .si(si_pin),
    .so(so_line));
  // ****************************************
  // Helpers
  // ****************************************
  // Random source
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction : rnd
  // Expected status word
  function automatic logic [23:0] exp_stat(logic [21:0] s, logic [7:0] b, int c);
    logic [23:0] e;
    e = {2'b00, ~s};
    for (int i = 0; i < N_PROG; i++)
      if (b[i])
        e[i] = s[i];
    if (c < N_IN)
      e[c] = 1'b0;
    return e;
  endfunction : exp_stat
  // Compare and count
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  // One 24-bit command
  task automatic cmd(input logic [7:0] op, input logic [15:0] arg);
    u_host.xfer({24'h0, op, arg}, 24, rx);
  endtask : cmd
  // New switch levels, left to settle
  task automatic set_sense(input logic [N_IN-1:0] v);
    @(negedge core_clk);
    sense_above_thr = v;
    repeat (6) @(negedge core_clk);
  endtask : set_sense
  // Verdict
  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test
  // ****************************************
  // Clock, watchdog, tests
  // ****************************************
  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  initial
  begin
    #600000;
    n_errors++;
    finish_test();
  end
  initial
  begin
    reset_n = 1'b0;
    sense_above_thr = '0;
    logic_supply_ok = 1'b1;
    other_wake_n = 1'b1;
    batt = 8'hFF;
    repeat (10) @(negedge core_clk);
    reset_n = 1'b1;
    repeat (4) @(negedge core_clk);
    check("sleep", sleep_mode, 0);
    check("src", src_en, 0);
    check("analog", analog_select_out, RST_ANA_CH);
    check("wake_oe", wake_n_oe_n, 0);
    $display("Test reset done");
    // Corner and random switch patterns
    for (int k = 0; k < 6; k++)
    begin
      r = rnd();
      set_sense((k == 0) ? 22'h0 : (k == 1) ? 22'h3FFFFF : r[21:0]);
      cmd(OP_STATUS, 16'h0);
      check("status", rx[23:0], exp_stat(sense_above_thr, batt, 31));
    end
    $display("Test status done");
    // Gate drive set-up, then toggling by type
    r = rnd();
    p = r[2:0];
    g = 8 + r[5:3];
    cmd(OP_WET_TIMER, ~((16'h1 << p) | (16'h1 << g)));
    cmd(OP_METALLIC, 16'hFFFF);
    cmd(OP_SETTINGS, 16'h00FF);
    cmd(OP_TRISTATE, ~(16'h1 << p));
    check("sink", {sink_en[p], src_en[p], hi_current[p]}, 3'b101);
    cmd(OP_SETTINGS, 16'h00FF & ~(16'h1 << p));
    check("source", {sink_en[p], src_en[p]}, 2'b01);
    cmd(OP_SETTINGS, 16'h00FF);
    check("sink", {sink_en[p], src_en[p]}, 2'b10);
    cmd(OP_TRISTATE, ~(16'h1 << g));
    check("gnd_on", {src_en[g], hi_current[g]}, 2'b11);
    cmd(OP_TRISTATE, 16'hFFFF);
    check("gnd_off", src_en[g], 0);
    $display("Test drive done");
    // Every analog option, boundary channel, then an invalid code
    set_sense(22'h0);
    for (int o = 0; o < 4; o++)
    begin
      r = rnd();
      ch = (o == 3) ? 21 : 8 + r[2:0];
      cmd(OP_ANALOG, {9'h0, o[1:0], ch[4:0]});
      check("channel", {analog_valid, analog_select_out}, {1'b1, ch[4:0]});
      check("asrc", src_en[ch], (o == 1 || o == 2));
      if (o == 1 || o == 2)
        check("ahi", hi_current[ch], (o == 2));
      cmd(OP_STATUS, 16'h0);
      check("astat", rx[23:0], exp_stat(sense_above_thr, batt, ch));
    end
    cmd(OP_ANALOG, 16'h0016);
    check("avalid", analog_valid, 0);
    $display("Test analog done");
    // Sleep entry, the two wake paths, no wake without supply, then an aborted sleep
    r = rnd();
    cmd(OP_SLEEP, {10'h0, r[5:0]});
    check("sleep", {sleep_mode, wake_n_oe_n}, 2'b11);
    check("timers", {int_timer_sel, scan_timer_sel}, r[5:0]);
    cmd(OP_STATUS, 16'h0);
    check("cswake", {sleep_mode, wake_n_oe_n}, 2'b00);
    cmd(OP_SLEEP, 16'h0);
    logic_supply_ok = 1'b0;
    cmd(OP_STATUS, 16'h0);
    check("nowake", sleep_mode, 1);
    logic_supply_ok = 1'b1;
    repeat (4) @(negedge core_clk);
    other_wake_n = 1'b0;
    repeat (10) @(negedge core_clk);
    check("linewake", {sleep_mode, wake_n_oe_n}, 2'b00);
    other_wake_n = 1'b1;
    fork
      cmd(OP_SLEEP, 16'h0);
      #1600 sense_above_thr = ~sense_above_thr;
    join
    check("abort", sleep_mode, 0);
    cmd(OP_STATUS, 16'h0);
    cmd(OP_STATUS, 16'h0);
    check("resync", rx[23:0], exp_stat(sense_above_thr, batt, 31));
    $display("Test sleep done");
    // Two chained words in one 48-clock frame
    u_host.xfer({24'h050003, 24'h050009}, 48, rx);
    check("chain", {analog_select_out, rx[23:0]}, {5'h09, 24'h050003});
    $display("Test chain done");
    // Second reset in mid-run
    @(negedge core_clk);
    reset_n = 1'b0;
    repeat (2) @(negedge core_clk);
    reset_n = 1'b1;
    repeat (4) @(negedge core_clk);
    check("rst", {sleep_mode, src_en, analog_select_out}, {1'b0, 22'h0, RST_ANA_CH});
    cmd(OP_SETTINGS, 16'h00FF);
    cmd(OP_STATUS, 16'h0);
    check("rstat", rx[23:0], exp_stat(sense_above_thr, 8'hFF, 31));
    $display("Test second reset done");
    finish_test();
  end
endmodule : testbench
